// File: design/tid_pkg.sv
// Package: constants, register map and carrier types for the trap and interrupt dispatcher
// How it works
// - Float underflow writes exact zero; enable gates trap
// - Inexact stores rounded result; enable gates trap
// - Integer overflow writes truncated result, flagged
// - Overflow enable honoured per integer and convert
// - Sync traps halt issue of later instructions
// - Sync traps save address of next instruction
// - Misaligned longword or quadword access traps
// - Fixup bit zero reports; one returns quietly
// - Locked or conditional misaligned gives illegal operand
// - Alignment vector 280; r4 address, r5 direction
// - Fixup bit mirrored at context word bit 63
// - Vector in r2, parameter in r3; mode choice
// - Reserved, subsetted or unprivileged opcode traps
// - Bad restored status or operand traps
// - Change-mode frames go on entered mode stack
// - Higher request raises level, kernel entry
// - In-flight work drains; exception frame goes first
// - Fixed priority levels per interrupt source
// - Interrupt frame eight quadwords; next unexecuted PC
// - Own vector per source; device vectors assignable
// - Interrupt entry leaves mapping state untouched
// - Priority level private to this processor
// - Summary bits four, five, six for arithmetic
// - Arithmetic traps: kernel, mask r4, summary r5
package tid_pkg;
   localparam int unsigned TID_AW = 12;
   localparam logic [11:0] TID_OFF_IPL = 12'h000;
   localparam logic [11:0] TID_OFF_FIXUP = 12'h004;
   localparam logic [11:0] TID_OFF_CTX_HI = 12'h008;
   localparam logic [11:0] TID_OFF_SOFT_REQ = 12'h00c;
   localparam logic [11:0] TID_OFF_SOFT_SUM = 12'h010;
   localparam logic [11:0] TID_OFF_EXC_SUM = 12'h014;
   localparam logic [11:0] TID_OFF_WMASK_LO = 12'h018;
   localparam logic [11:0] TID_OFF_WMASK_HI = 12'h01c;
   localparam logic [11:0] TID_OFF_DEV_VEC = 12'h020;
   localparam logic [11:0] TID_OFF_STATUS = 12'h024;
   localparam logic [15:0] TID_DEV_VEC_RST = 16'h0800;
   localparam logic [15:0] TID_DEV_VEC_STEP = 16'h0010;
   // Exception summary and context-block positions
   localparam int unsigned TID_SUM_UNF = 4;
   localparam int unsigned TID_SUM_INE = 5;
   localparam int unsigned TID_SUM_IOV = 6;
   localparam int unsigned TID_CTX_FIXUP_BIT = 31;
   // Priority levels
   localparam logic [4:0] TID_LVL_AST = 5'h02;
   localparam logic [4:0] TID_LVL_DEV0 = 5'h14;
   localparam logic [4:0] TID_LVL_TICK = 5'h16;
   localparam logic [4:0] TID_LVL_IPI = 5'h16;
   localparam logic [4:0] TID_LVL_PERF = 5'h1d;
   localparam logic [4:0] TID_LVL_POWER = 5'h1e;
   localparam int unsigned TID_SOFT_LO = 1;
   localparam int unsigned TID_SOFT_HI = 15;
   localparam int unsigned TID_NDEV = 4;
   // Control-block vectors; only alignment is fixed, the rest are arbitrary
   localparam logic [15:0] TID_VEC_ALIGN = 16'h0280;
   localparam logic [15:0] TID_VEC_ARITH = 16'h0200;
   localparam logic [15:0] TID_VEC_BREAK = 16'h0400;
   localparam logic [15:0] TID_VEC_ERRLOG = 16'h0410;
   localparam logic [15:0] TID_VEC_ILL_INSTR = 16'h0420;
   localparam logic [15:0] TID_VEC_ILL_OPND = 16'h0430;
   localparam logic [15:0] TID_VEC_SWTRAP = 16'h0440;
   localparam logic [15:0] TID_VEC_ENTER = 16'h0480;
   localparam logic [15:0] TID_VEC_SOFT = 16'h0500;
   localparam logic [15:0] TID_VEC_AST = 16'h0240;
   localparam logic [15:0] TID_VEC_TICK = 16'h0600;
   localparam logic [15:0] TID_VEC_IPI = 16'h0610;
   localparam logic [15:0] TID_VEC_PERF = 16'h0650;
   localparam logic [15:0] TID_VEC_POWER = 16'h0660;
   localparam int unsigned TID_FRAME_QW = 8;

   typedef enum logic [1:0] {TID_KERNEL, TID_EXEC, TID_SUPER, TID_USER} tid_mode_t;
   typedef enum logic [1:0] {TID_SZ_BYTE, TID_SZ_WORD, TID_SZ_LONG, TID_SZ_QUAD} tid_size_t;
   typedef enum logic [2:0] {TID_CALL_NONE, TID_CALL_BREAK, TID_CALL_ERRLOG, TID_CALL_SWTRAP,
      TID_CALL_ENTER_K, TID_CALL_ENTER_E, TID_CALL_ENTER_S, TID_CALL_ENTER_U} tid_call_t;
   typedef enum logic [1:0] {TID_OP_FLOAT, TID_OP_IEEE, TID_OP_INT, TID_OP_CVT_INT} tid_op_t;
   typedef enum logic [3:0] {TID_C_NONE, TID_C_ALIGN, TID_C_ILL_OPND, TID_C_ILL_INSTR, TID_C_CALL,
      TID_C_ARITH, TID_C_INTR} tid_cause_t;

   typedef struct packed {
      logic valid;
      logic [63:0] pc;
      logic [63:0] param;
      logic mem_valid;
      logic [63:0] mem_addr;
      tid_size_t mem_size;
      logic mem_write;
      logic mem_locked;
      tid_call_t call;
      logic reserved_op;
      logic subset_op;
      logic priv_op;
      logic bad_ps;
      logic bad_operand;
   } tid_exc_req_t;

   typedef struct packed {
      logic valid;
      tid_op_t op;
      logic [5:0] dest;
      logic [127:0] true_result;
      logic underflow;
      logic inexact;
      logic overflow;
      logic unf_en;
      logic ine_en;
      logic iov_en;
   } tid_arith_t;

   typedef struct packed {
      logic valid;
      logic [5:0] dest;
      logic [63:0] value;
      logic int_ovf;
   } tid_wb_t;

   typedef struct packed {
      logic valid;
      tid_mode_t mode;
      logic [4:0] interrupt_priority_level;
   } tid_restore_t;

   typedef struct packed {
      logic valid;
      tid_cause_t cause;
      tid_mode_t entry_mode;
      tid_mode_t stack_mode;
      logic [4:0] new_ipl;
      logic [63:0] saved_pc;
      logic [63:0] r2;
      logic [63:0] r3;
      logic [63:0] r4;
      logic [63:0] r5;
      logic report_os;
      logic [3:0] frame_qw;
   } tid_disp_t;
endpackage : tid_pkg

// File: design/tid_dispatch.sv
// Module: trap and interrupt dispatcher with APB register slave
`timescale 1ns/1ps
module tid_dispatch (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tid_pkg::TID_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tid_pkg::tid_exc_req_t exc_req,
   input wire tid_pkg::tid_arith_t arith_req,
   input wire logic pipe_idle,
   input wire logic [63:0] next_pc,
   input wire tid_pkg::tid_restore_t restore,
   input wire logic ctx_load_valid,
   input wire logic ctx_load_fixup,
   input wire logic ast_req,
   input wire logic [tid_pkg::TID_NDEV-1:0] dev_irq,
   input wire logic tick_irq,
   input wire logic ipi_irq,
   input wire logic perf_irq,
   input wire logic power_irq,
   output tid_pkg::tid_wb_t wb,
   output tid_pkg::tid_disp_t disp,
   output logic issue_hold
);
   import tid_pkg::*;

   typedef enum logic [2:0] {TID_S_NONE, TID_S_SOFT, TID_S_AST, TID_S_DEV, TID_S_TICK, TID_S_IPI,
      TID_S_PERF, TID_S_POWER} tid_src_t;

   // Pin requests: two flops before use
   logic [8:0] pin_raw;
   logic [8:0] pin_meta_q;
   logic [8:0] pin_sync_q;
   assign pin_raw = {power_irq, perf_irq, ipi_irq, tick_irq, dev_irq, 1'b0};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta_q <= 9'h000;
         pin_sync_q <= 9'h000;
      end
      else
      begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   logic [TID_NDEV-1:0] dev_s;
   logic tick_s;
   logic ipi_s;
   logic perf_s;
   logic power_s;
   assign dev_s = pin_sync_q[TID_NDEV:1];
   assign tick_s = pin_sync_q[5];
   assign ipi_s = pin_sync_q[6];
   assign perf_s = pin_sync_q[7];
   assign power_s = pin_sync_q[8];

   // State
   logic [4:0] ipl_q;
   tid_mode_t mode_q;
   logic fixup_q;
   logic ctx_fixup_q;
   logic [15:1] soft_pend_q;
   logic [6:0] sum_q;
   logic [63:0] wmask_q;
   logic [15:0] dev_vec_q;
   tid_disp_t disp_q;
   tid_wb_t wb_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // APB decode
   logic apb_wr;
   logic apb_rd;
   logic mapped;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   always_comb
   begin
      if (paddr == TID_OFF_IPL)
         mapped = 1'b1;
      else if (paddr == TID_OFF_FIXUP)
         mapped = 1'b1;
      else if (paddr == TID_OFF_CTX_HI)
         mapped = 1'b1;
      else if (paddr == TID_OFF_SOFT_REQ)
         mapped = 1'b1;
      else if (paddr == TID_OFF_SOFT_SUM)
         mapped = 1'b1;
      else if (paddr == TID_OFF_EXC_SUM)
         mapped = 1'b1;
      else if (paddr == TID_OFF_WMASK_LO)
         mapped = 1'b1;
      else if (paddr == TID_OFF_WMASK_HI)
         mapped = 1'b1;
      else if (paddr == TID_OFF_DEV_VEC)
         mapped = 1'b1;
      else if (paddr == TID_OFF_STATUS)
         mapped = 1'b1;
      else
         mapped = 1'b0;
   end

   // Arithmetic writeback
   logic a_unf;
   logic a_ine;
   logic a_iov;
   logic a_iov_ok;
   assign a_iov_ok = (arith_req.op == TID_OP_INT) || (arith_req.op == TID_OP_CVT_INT);
   assign a_unf = arith_req.valid && arith_req.underflow && arith_req.unf_en;
   assign a_ine = arith_req.valid && arith_req.inexact && arith_req.ine_en && (arith_req.op == TID_OP_IEEE);
   assign a_iov = arith_req.valid && arith_req.overflow && arith_req.iov_en && a_iov_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wb_q <= '0;
      else
      begin
         wb_q.valid <= arith_req.valid;
         wb_q.dest <= arith_req.dest;
         wb_q.int_ovf <= arith_req.valid && arith_req.overflow && a_iov_ok;
         if (arith_req.underflow && (arith_req.op != TID_OP_INT))
            wb_q.value <= 64'h0000_0000_0000_0000;
         else
            wb_q.value <= arith_req.true_result[63:0];
      end
   end
   assign wb = wb_q;

   // Synchronous exception decode
   logic misaligned;
   logic sync_hit;
   tid_cause_t sync_cause;
   always_comb
   begin
      misaligned = 1'b0;
      if (exc_req.mem_valid && exc_req.mem_size == TID_SZ_LONG)
         misaligned = exc_req.mem_addr[1:0] != 2'h0;
      else if (exc_req.mem_valid && exc_req.mem_size == TID_SZ_QUAD)
         misaligned = exc_req.mem_addr[2:0] != 3'h0;
   end

   always_comb
   begin
      sync_cause = TID_C_NONE;
      if (exc_req.valid)
      begin
         if (exc_req.reserved_op || exc_req.subset_op || (exc_req.priv_op && mode_q != TID_KERNEL))
            sync_cause = TID_C_ILL_INSTR;
         else if (exc_req.bad_ps || exc_req.bad_operand || (misaligned && exc_req.mem_locked))
            sync_cause = TID_C_ILL_OPND;
         else if (misaligned)
            sync_cause = TID_C_ALIGN;
         else if (exc_req.call != TID_CALL_NONE)
            sync_cause = TID_C_CALL;
      end
   end
   assign sync_hit = sync_cause != TID_C_NONE;

   // Change-mode target
   tid_mode_t call_target;
   tid_mode_t call_entry;
   logic [15:0] call_vec;
   always_comb
   begin
      call_vec = TID_VEC_ENTER;
      case (exc_req.call)
         TID_CALL_BREAK: call_vec = TID_VEC_BREAK;
         TID_CALL_ERRLOG: call_vec = TID_VEC_ERRLOG;
         TID_CALL_SWTRAP: call_vec = TID_VEC_SWTRAP;
         TID_CALL_ENTER_E: call_vec = TID_VEC_ENTER + TID_DEV_VEC_STEP;
         TID_CALL_ENTER_S: call_vec = TID_VEC_ENTER + TID_DEV_VEC_STEP + TID_DEV_VEC_STEP;
         TID_CALL_ENTER_U: call_vec = TID_VEC_ENTER + TID_DEV_VEC_STEP + TID_DEV_VEC_STEP + TID_DEV_VEC_STEP;
         default: call_vec = TID_VEC_ENTER;
      endcase
   end

   always_comb
   begin
      case (exc_req.call)
         TID_CALL_ENTER_E: call_target = TID_EXEC;
         TID_CALL_ENTER_S: call_target = TID_SUPER;
         TID_CALL_ENTER_U: call_target = TID_USER;
         default: call_target = TID_KERNEL;
      endcase
      // Lower encoding is more privileged
      call_entry = (mode_q < call_target) ? mode_q : call_target;
   end

   // Interrupt arbitration; later entries only win on a strictly higher level
   logic [4:0] best_lvl;
   tid_src_t best_src;
   logic [1:0] best_dev;
   always_comb
   begin
      best_lvl = 5'h00;
      best_src = TID_S_NONE;
      best_dev = 2'h0;
      if (power_s && TID_LVL_POWER > best_lvl)
      begin
         best_lvl = TID_LVL_POWER;
         best_src = TID_S_POWER;
      end
      if (perf_s && TID_LVL_PERF > best_lvl)
      begin
         best_lvl = TID_LVL_PERF;
         best_src = TID_S_PERF;
      end
      if (tick_s && TID_LVL_TICK > best_lvl)
      begin
         best_lvl = TID_LVL_TICK;
         best_src = TID_S_TICK;
      end
      if (ipi_s && TID_LVL_IPI > best_lvl)
      begin
         best_lvl = TID_LVL_IPI;
         best_src = TID_S_IPI;
      end
      for (int i = TID_NDEV - 1; i >= 0; i--)
      begin
         if (dev_s[i] && (TID_LVL_DEV0 + 5'(i)) > best_lvl)
         begin
            best_lvl = TID_LVL_DEV0 + 5'(i);
            best_src = TID_S_DEV;
            best_dev = 2'(i);
         end
      end
      if (ast_req && TID_LVL_AST > best_lvl)
      begin
         best_lvl = TID_LVL_AST;
         best_src = TID_S_AST;
      end
      for (int j = TID_SOFT_HI; j >= TID_SOFT_LO; j--)
      begin
         if (soft_pend_q[j] && 5'(j) > best_lvl)
         begin
            best_lvl = 5'(j);
            best_src = TID_S_SOFT;
         end
      end
   end

   logic [15:0] intr_vec;
   always_comb
   begin
      case (best_src)
         TID_S_POWER: intr_vec = TID_VEC_POWER;
         TID_S_PERF: intr_vec = TID_VEC_PERF;
         TID_S_TICK: intr_vec = TID_VEC_TICK;
         TID_S_IPI: intr_vec = TID_VEC_IPI;
         TID_S_DEV: intr_vec = dev_vec_q + (TID_DEV_VEC_STEP * {14'h0000, best_dev});
         TID_S_AST: intr_vec = TID_VEC_AST + (TID_DEV_VEC_STEP * {14'h0000, mode_q});
         default: intr_vec = TID_VEC_SOFT + (TID_DEV_VEC_STEP * {11'h000, best_lvl});
      endcase
   end

   // Dispatch selection: sync exceptions, then pending arithmetic, then interrupts
   logic arith_pend;
   logic arith_take;
   logic intr_take;
   assign arith_pend = sum_q[TID_SUM_UNF] || sum_q[TID_SUM_INE] || sum_q[TID_SUM_IOV];
   assign arith_take = !sync_hit && arith_pend && pipe_idle && !arith_req.valid;
   assign intr_take = !sync_hit && !arith_pend && pipe_idle && !arith_req.valid
      && (best_lvl > ipl_q);
   assign issue_hold = sync_hit || arith_pend || a_unf || a_ine || a_iov;

   tid_disp_t disp_d;
   always_comb
   begin
      disp_d = '0;
      disp_d.entry_mode = TID_KERNEL;
      disp_d.stack_mode = TID_KERNEL;
      disp_d.new_ipl = ipl_q;
      disp_d.saved_pc = exc_req.pc + 64'h0000_0000_0000_0004;
      disp_d.r3 = exc_req.param;
      if (sync_hit)
      begin
         disp_d.valid = 1'b1;
         disp_d.cause = sync_cause;
         case (sync_cause)
            TID_C_ALIGN:
            begin
               disp_d.r2 = 64'(TID_VEC_ALIGN);
               disp_d.r4 = exc_req.mem_addr;
               disp_d.r5 = {63'h0, exc_req.mem_write};
               disp_d.report_os = !fixup_q;
            end
            TID_C_ILL_OPND: disp_d.r2 = 64'(TID_VEC_ILL_OPND);
            TID_C_ILL_INSTR: disp_d.r2 = 64'(TID_VEC_ILL_INSTR);
            default:
            begin
               disp_d.r2 = 64'(call_vec);
               disp_d.entry_mode = call_entry;
               disp_d.stack_mode = call_entry;
            end
         endcase
      end
      else if (arith_take)
      begin
         disp_d.valid = 1'b1;
         disp_d.cause = TID_C_ARITH;
         disp_d.saved_pc = next_pc;
         disp_d.r2 = 64'(TID_VEC_ARITH);
         disp_d.r3 = 64'h0000_0000_0000_0000;
         disp_d.r4 = wmask_q;
         disp_d.r5 = {57'h0, sum_q};
      end
      else if (intr_take)
      begin
         // Translation state is never touched on this path
         disp_d.valid = 1'b1;
         disp_d.cause = TID_C_INTR;
         disp_d.new_ipl = best_lvl;
         disp_d.saved_pc = next_pc;
         disp_d.r2 = 64'(intr_vec);
         disp_d.r3 = {59'h0, best_lvl};
         disp_d.frame_qw = 4'(TID_FRAME_QW);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         disp_q <= '0;
      else
         disp_q <= disp_d;
   end
   assign disp = disp_q;

   // Priority level and mode; local copy only, never shared
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ipl_q <= 5'h1f;
         mode_q <= TID_KERNEL;
      end
      else if (disp_d.valid)
      begin
         ipl_q <= disp_d.new_ipl;
         mode_q <= disp_d.entry_mode;
      end
      else if (restore.valid)
      begin
         ipl_q <= restore.interrupt_priority_level;
         mode_q <= restore.mode;
      end
      else if (apb_wr && paddr == TID_OFF_IPL && pstrb[0])
         ipl_q <= pwdata[4:0];
   end

   // Alignment fixup control and its context-block copy
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fixup_q <= 1'b0;
         ctx_fixup_q <= 1'b0;
      end
      else if (apb_wr && paddr == TID_OFF_FIXUP && pstrb[0])
      begin
         fixup_q <= pwdata[0];
         ctx_fixup_q <= pwdata[0];
      end
      else if (ctx_load_valid)
      begin
         fixup_q <= ctx_load_fixup;
         ctx_fixup_q <= ctx_load_fixup;
      end
   end

   // Software interrupt pending; a new request beats a same-cycle clear
   logic [15:1] soft_set;
   logic [15:1] soft_clr;
   always_comb
   begin
      soft_set = '0;
      soft_clr = '0;
      if (apb_wr && paddr == TID_OFF_SOFT_REQ && pstrb[0] && pwdata[3:0] != 4'h0)
         soft_set[pwdata[3:0]] = 1'b1;
      if (intr_take && best_src == TID_S_SOFT)
         soft_clr[best_lvl[3:0]] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         soft_pend_q <= '0;
      else
         soft_pend_q <= (soft_pend_q & ~soft_clr) | soft_set;
   end

   // Arithmetic summary and write mask gather until the trap is taken
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sum_q <= 7'h00;
         wmask_q <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         if (arith_take)
         begin
            sum_q <= 7'h00;
            wmask_q <= 64'h0000_0000_0000_0000;
         end
         if (a_unf || a_ine || a_iov)
         begin
            sum_q[TID_SUM_UNF] <= sum_q[TID_SUM_UNF] && !arith_take || a_unf;
            sum_q[TID_SUM_INE] <= sum_q[TID_SUM_INE] && !arith_take || a_ine;
            sum_q[TID_SUM_IOV] <= sum_q[TID_SUM_IOV] && !arith_take || a_iov;
            wmask_q <= (arith_take ? 64'h0000_0000_0000_0000 : wmask_q)
               | (64'h0000_0000_0000_0001 << arith_req.dest);
         end
      end
   end

   // Device vector base
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dev_vec_q <= TID_DEV_VEC_RST;
      else if (apb_wr && paddr == TID_OFF_DEV_VEC && pstrb[0] && pstrb[1])
         dev_vec_q <= pwdata[15:0];
   end

   // Read data and error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pslverr_q <= psel && !penable && !mapped;
         prdata_q <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
         begin
            if (paddr == TID_OFF_IPL)
               prdata_q <= {27'h0, ipl_q};
            else if (paddr == TID_OFF_FIXUP)
               prdata_q <= {31'h0, fixup_q};
            else if (paddr == TID_OFF_CTX_HI)
               prdata_q <= 32'(ctx_fixup_q) << TID_CTX_FIXUP_BIT;
            else if (paddr == TID_OFF_SOFT_SUM)
               prdata_q <= {16'h0, soft_pend_q, 1'b0};
            else if (paddr == TID_OFF_EXC_SUM)
               prdata_q <= {25'h0, sum_q};
            else if (paddr == TID_OFF_WMASK_LO)
               prdata_q <= wmask_q[31:0];
            else if (paddr == TID_OFF_WMASK_HI)
               prdata_q <= wmask_q[63:32];
            else if (paddr == TID_OFF_DEV_VEC)
               prdata_q <= {16'h0, dev_vec_q};
            else if (paddr == TID_OFF_STATUS)
               prdata_q <= {28'h0, arith_pend, 1'b0, mode_q};
         end
      end
   end

   logic unused_rd;
   assign unused_rd = apb_rd;
endmodule : tid_dispatch

// File: verification/tid_pipe_model.sv
// Pipeline stand-in
`timescale 1ns/1ps
module tid_pipe_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic issue_hold,
   output logic pipe_idle,
   output logic [63:0] next_pc
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         next_pc <= 64'h1000;
         pipe_idle <= 1'b0;
      end
      else
      begin
         if (!issue_hold) next_pc <= next_pc + 64'h4;
         pipe_idle <= issue_hold || next_pc[3]; // Drains while held
      end
   end
endmodule : tid_pipe_model

// File: verification/tid_dispatch_chk.sv
// Checker: dispatch properties
`timescale 1ns/1ps
module tid_dispatch_chk
   import tid_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire tid_pkg::tid_exc_req_t exc_req,
   input wire tid_pkg::tid_arith_t arith_req,
   input wire tid_pkg::tid_wb_t wb,
   input wire tid_pkg::tid_disp_t disp,
   input wire logic issue_hold
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic mis, ill, go;
   assign mis = exc_req.mem_valid && exc_req.mem_size == TID_SZ_QUAD && exc_req.mem_addr[2:0] != 3'h0;
   assign ill = exc_req.reserved_op || exc_req.subset_op || exc_req.bad_ps || exc_req.bad_operand;
   assign go = exc_req.valid && !ill && !exc_req.priv_op && mis;
   sequence s_out(tid_cause_t c);
      disp.valid && disp.cause == c;
   endsequence
   property p_unf;
      arith_req.valid && arith_req.underflow && !arith_req.op[1] |=> wb.valid && wb.value == 64'h0;
   endproperty
   a_unf: assert property (p_unf) else $error("unf value");
   property p_iov;
      arith_req.valid && arith_req.overflow && arith_req.op[1] |=>
         wb.int_ovf && wb.value == $past(arith_req.true_result[63:0]);
   endproperty
   a_iov: assert property (p_iov) else $error("iov value");
   property p_hold;
      exc_req.valid && ill |-> issue_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_ill;
      exc_req.valid && exc_req.reserved_op |=> s_out(TID_C_ILL_INSTR);
   endproperty
   a_ill: assert property (p_ill) else $error("no ill instr");
   property p_lock;
      go && exc_req.mem_locked |=> s_out(TID_C_ILL_OPND);
   endproperty
   a_lock: assert property (p_lock) else $error("no ill operand");
   property p_align;
      go && !exc_req.mem_locked |=> s_out(TID_C_ALIGN) ##0 disp.r2 == 64'h280 && disp.r4 == $past(exc_req.mem_addr);
   endproperty
   a_align: assert property (p_align) else $error("bad align");
   property p_spc;
      disp.valid && disp.cause inside {TID_C_ALIGN, TID_C_ILL_INSTR, TID_C_CALL} |->
         disp.saved_pc == $past(exc_req.pc) + 64'h4;
   endproperty
   a_spc: assert property (p_spc) else $error("bad pc");
   property p_intr;
      s_out(TID_C_INTR) |-> disp.frame_qw == 4'h8 && {disp.entry_mode, disp.stack_mode} == 4'h0;
   endproperty
   a_intr: assert property (p_intr) else $error("bad frame");
endmodule : tid_dispatch_chk

// File: verification/trap_and_interrupt_dispatch_bench.sv
// Testbench top
`timescale 1ns/1ps
module trap_and_interrupt_dispatch_bench;
   import tid_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, err, issue_hold, pipe_idle;
   logic [63:0] next_pc;
   logic [7:0] irq = 8'h0;
   tid_exc_req_t exc = '0;
   tid_arith_t ar = '0;
   tid_restore_t rs = '0;
   tid_wb_t wb;
   tid_disp_t disp;
   int error_cnt = 0, n_tests = 0;
   always #2.5 pclk = ~pclk;
   tid_dispatch i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
      .pslverr, .exc_req(exc), .arith_req(ar), .pipe_idle, .next_pc, .restore(rs), .ctx_load_valid(1'b0),
      .ctx_load_fixup(1'b0), .ast_req(1'b0), .dev_irq(irq[3:0]), .tick_irq(irq[4]), .ipi_irq(irq[5]),
      .perf_irq(irq[6]), .power_irq(irq[7]), .wb, .disp, .issue_hold);
   tid_pipe_model i_pipe (.pclk, .presetn, .issue_hold, .pipe_idle, .next_pc);
   task automatic chk(input logic [63:0] got, exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize;
      if (error_cnt == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic trap(input tid_exc_req_t e, output tid_disp_t d);
      exc <= e;
      @(posedge pclk);
      exc <= '0;
      @(negedge pclk);
      d = disp;
      @(posedge pclk);
   endtask : trap
   task automatic set_ps(input tid_mode_t m, input logic [4:0] l);
      rs <= '{1'b1, m, l};
      @(posedge pclk);
      rs <= '0;
      @(posedge pclk);
   endtask : set_ps
   function automatic logic [63:0] exp_val(input tid_arith_t a);
      return (a.underflow && !a.op[1]) ? 64'h0 : a.true_result[63:0];
   endfunction : exp_val
   function automatic logic [4:0] lvl(input int i);
      return i < 4 ? 5'h14 + 5'(i) : (i < 6 ? 5'h16 : 5'h17 + 5'(i));
   endfunction : lvl
   initial
   begin
      #20000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      logic [31:0] q;
      tid_disp_t d;
      tid_exc_req_t x;
      tid_arith_t a;
      int n;
      q = $urandom(32'h4855_82ee);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, TID_OFF_IPL, 32'h0, q);
      chk(q, 32'h1f);
      apb(1'b0, 12'h040, 32'h0, q);
      chk({q, err}, 33'h1);
      apb(1'b1, TID_OFF_FIXUP, 32'h1, q);
      apb(1'b0, TID_OFF_CTX_HI, 32'h0, q);
      chk(q, 32'h8000_0000);
      for (int f = 1; f >= 0; f--)
      begin
         apb(1'b1, TID_OFF_FIXUP, 32'(f), q);
         x = '0;
         x.valid = 1'b1;
         x.pc = {32'h0, $urandom} & ~64'h3;
         x.mem_valid = 1'b1;
         x.mem_size = TID_SZ_QUAD;
         x.mem_addr = {$urandom, $urandom} | 64'h1;
         x.mem_write = f[0];
         trap(x, d);
         chk(d.cause, TID_C_ALIGN);
         chk({d.r5[62:0], d.report_os}, {62'h0, x.mem_write, ~f[0]});
         chk(d.saved_pc, x.pc + 64'h4);
         x.mem_locked = 1'b1;
         trap(x, d);
         chk(d.cause, TID_C_ILL_OPND);
      end
      for (int i = 0; i < 4; i++)
      begin
         set_ps(TID_USER, 5'h1f);
         x = '0;
         x.valid = 1'b1;
         {x.bad_ps, x.priv_op, x.subset_op, x.reserved_op} = 4'h1 << i;
         trap(x, d);
         chk(d.cause, i < 3 ? TID_C_ILL_INSTR : TID_C_ILL_OPND);
      end
      for (int c = 1; c < 8; c++)
      begin
         set_ps(TID_USER, 5'h1f);
         x = '0;
         x.valid = 1'b1;
         x.call = tid_call_t'(c);
         trap(x, d);
         chk({d.cause, d.entry_mode, d.stack_mode}, {TID_C_CALL, {2{c > 3 ? 2'(c - 4) : 2'h0}}});
      end
      for (int i = 0; i < 40; i++)
      begin
         a = '0;
         a.valid = 1'b1;
         a.op = tid_op_t'($urandom_range(3));
         a.dest = 6'($urandom);
         a.true_result = {$urandom, $urandom, $urandom, $urandom};
         a.underflow = !a.op[1] && 1'($urandom);
         a.inexact = a.op == TID_OP_IEEE && 1'($urandom);
         a.overflow = a.op[1] && 1'($urandom);
         {a.unf_en, a.ine_en, a.iov_en} = 3'($urandom);
         ar <= a;
         @(posedge pclk);
         ar <= '0;
         @(negedge pclk);
         chk(wb.value, exp_val(a));
         chk(wb.int_ovf, a.overflow);
         @(posedge pclk);
      end
      for (int i = 0; i < 8; i++)
      begin
         set_ps(TID_KERNEL, 5'h0);
         irq <= 8'h1 << i;
         n = 0;
         do
         begin
            @(negedge pclk);
            n++;
         end
         while (!(disp.valid === 1'b1 && disp.cause === TID_C_INTR) && n < 40);
         chk({disp.valid, disp.new_ipl, disp.r3[4:0]}, {1'b1, lvl(i), lvl(i)});
         @(posedge pclk);
         irq <= 8'h0;
         repeat (8) @(posedge pclk);
      end
      summarize();
   end
endmodule : trap_and_interrupt_dispatch_bench
bind tid_dispatch tid_dispatch_chk i_chk (.pclk, .presetn, .exc_req, .arith_req, .wb, .disp, .issue_hold);
